//--- verilog/ste_defs.svh
`ifndef STE_DEFS_SVH
`define STE_DEFS_SVH

// **********************************************
// Word timing
// **********************************************
`define STE_WORD_CYCLES      4'd10
`define STE_CAPTURE_PHASE    4'd9
`define STE_ENCODE_PHASE     4'd7
`define STE_BITS_PER_CYCLE   2
`define STE_TX_LAT_MIN_BITS  34
`define STE_TX_LAT_MAX_BITS  38
`define STE_LATENCY_CYCLES   18
`define STE_START_IDLES      3

// **********************************************
// Character values
// **********************************************
`define STE_K28_5            8'hBC
`define STE_D5_6             8'hC5
`define STE_D16_2            8'h50
`define STE_K23_7            8'hF7
`define STE_K30_7            8'hFE
`define STE_K_CODE28         5'h1C

// **********************************************
// Ten-bit patterns, bit 0 sent first
// **********************************************
`define STE_K28_5_NEG        10'h17C
`define STE_K28_5_POS        10'h283
`define STE_K23_7_NEG        10'h057
`define STE_K23_7_POS        10'h3A8
`define STE_K30_7_NEG        10'h05E
`define STE_K30_7_POS        10'h3A1

`endif

//--- verilog/ste_pkg.sv
package ste_pkg;

    // Kind of word presented by the protocol device
    typedef enum logic [1:0] {
        STE_DATA    = 2'b00,
        STE_IDLE    = 2'b01,
        STE_CAREXT  = 2'b10,
        STE_ERRPROP = 2'b11
    } ste_kind_e;

    // Link start-up state
    typedef enum logic {
        STE_START = 1'b0,
        STE_RUN   = 1'b1
    } ste_state_e;

    // Parallel side of the transmitter
    typedef struct packed {
        logic [15:0] word;
        logic        frameValid;
        logic        txErrorCode;
    } ste_tx_in_s;

    // Captured word with its decoded kind
    typedef struct packed {
        logic [15:0] word;
        ste_kind_e   kind;
    } ste_capt_s;

endpackage

//--- verilog/ste_serdes_transmit_encoder.sv
`timescale 1ns/1ps
`include "ste_defs.svh"

// Notes on behaviour
// RL1 - The parallel word is captured on the word clock edge and used when flagged valid.
// RL2 - Twenty bits leave per word, two per fast clock as the rising and falling edge bits.
// RL3 - Each code word leaves bit zero first and proceeds upward.
// RL4 - After reset the link opens with idle words carrying commas for byte alignment.
// RL5 - The protocol device raises frame valid with the first preamble word and holds it.
// RL6 - The protocol device drops frame valid before the edge after the last frame word.
// RL7 - The word splits into two bytes, each through its own 8b/10b encoder, giving 20 bits.
// RL8 - Frame valid high with error low sends both bytes as data characters.
// RL9 - Frame valid low with error high sends carrier extend, two K23.7 characters.
// RL10 - Frame valid and error both high send error propagation, two K30.7 characters.
// RL11 - Frame valid and error both low send idle, K28.5 then D5.6 or D16.2.
// RL12 - From capture to first serial bit takes a fixed 36 bit times, inside 34 to 38.
// RL13 - Encoding is standard 8b/10b with running disparity keeping the line balanced.
// RL14 - Idle fills every gap, and K28.5 from negative disparity is 0011111010.
// RL15 - The low byte forms the first ten bits and disparity runs on into the high byte.
// RL16 - The second idle character is chosen so the idle word ends at negative disparity.
module ste_serdes_transmit_encoder #(
    parameter int START_IDLES = `STE_START_IDLES
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Parallel transmit side
    input  wire ste_pkg::ste_tx_in_s txIn,
    output logic                  wordTake,
    // Serial side
    output logic [1:0]            serialPair,
    output logic                  linkUp
);

    // **********************************************
    // Parameter check
    // **********************************************
    if (START_IDLES < 1 || START_IDLES > 255) begin : g_bad_start
        $error("START_IDLES must lie in 1 to 255");
    end

    // **********************************************
    // 8b/10b character encoder
    // **********************************************
    // Returns {disparity out, ten bits with bit 0 sent first}
    function automatic logic [10:0] encByte(input logic [7:0] b, input logic k,
                                            input logic rdIn);
        logic [5:0] s;
        logic [3:0] q;
        logic [9:0] msbFirst;
        logic [9:0] r;
        logic       rd6;
        logic       alt;
        logic [4:0] x;
        logic [2:0] y;
        x = b[4:0];
        y = b[7:5];
        case (x)
            5'd0:  s = 6'b100111;
            5'd1:  s = 6'b011101;
            5'd2:  s = 6'b101101;
            5'd3:  s = 6'b110001;
            5'd4:  s = 6'b110101;
            5'd5:  s = 6'b101001;
            5'd6:  s = 6'b011001;
            5'd7:  s = 6'b111000;
            5'd8:  s = 6'b111001;
            5'd9:  s = 6'b100101;
            5'd10: s = 6'b010101;
            5'd11: s = 6'b110100;
            5'd12: s = 6'b001101;
            5'd13: s = 6'b101100;
            5'd14: s = 6'b011100;
            5'd15: s = 6'b010111;
            5'd16: s = 6'b011011;
            5'd17: s = 6'b100011;
            5'd18: s = 6'b010011;
            5'd19: s = 6'b110010;
            5'd20: s = 6'b001011;
            5'd21: s = 6'b101010;
            5'd22: s = 6'b011010;
            5'd23: s = 6'b111010;
            5'd24: s = 6'b110011;
            5'd25: s = 6'b100110;
            5'd26: s = 6'b010110;
            5'd27: s = 6'b110110;
            5'd28: s = k ? 6'b001111 : 6'b001110;
            5'd29: s = 6'b101110;
            5'd30: s = 6'b011110;
            default: s = 6'b101011;
        endcase
        // Positive disparity takes the complement of unbalanced codes
        if (rdIn && (($countones(s) != 3) || x == 5'd7)) begin // RL13
            s = ~s;
        end
        rd6 = rdIn ^ ($countones(s) != 3);
        alt = !k && y == 3'd7 &&
              ((!rd6 && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
               (rd6 && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
        case (y)
            3'd0: q = 4'b1011;
            3'd1: q = 4'b1001;
            3'd2: q = 4'b0101;
            3'd3: q = 4'b1100;
            3'd4: q = 4'b1101;
            3'd5: q = 4'b1010;
            3'd6: q = 4'b0110;
            default: q = (k || alt) ? 4'b0111 : 4'b1110;
        endcase
        if (rd6 && (($countones(q) != 2) || y == 3'd3)) begin // RL13
            q = ~q;
        end else if (!rd6 && k && x == `STE_K_CODE28 && $countones(q) == 2 && y != 3'd3) begin
            q = ~q;
        end
        msbFirst = {s, q};
        for (int i = 0; i < 10; i++) begin
            r[i] = msbFirst[9 - i];
        end
        return {rd6 ^ ($countones(q) != 2), r};
    endfunction

    // **********************************************
    // State
    // **********************************************
    logic [3:0]          phase;
    ste_pkg::ste_capt_s  capt;
    ste_pkg::ste_state_e state;
    logic [7:0]          idleCount;
    logic [19:0]         codeWord;
    logic [17:0]         shifter;
    logic                rd;

    // **********************************************
    // Decode and selection
    // **********************************************
    wire                 captureTick = (phase == `STE_CAPTURE_PHASE);
    wire                 encodeTick  = (phase == `STE_ENCODE_PHASE);
    wire [3:0]           next_phase  = (phase == `STE_WORD_CYCLES - 4'd1) ? 4'd0 : phase + 4'd1;
    wire ste_pkg::ste_kind_e inKind  = ste_pkg::ste_kind_e'({txIn.txErrorCode,
                                       ~(txIn.frameValid ^ txIn.txErrorCode)}); // RL8
    // Start-up forces idle so commas lead the link
    wire ste_pkg::ste_kind_e effKind = (state == ste_pkg::STE_START) ?
                                       ste_pkg::STE_IDLE : capt.kind; // RL4 RL14
    wire                 isData   = (effKind == ste_pkg::STE_DATA);
    // Control bytes for idle, carrier extend and error propagation
    wire [7:0]           loByte   = isData ? capt.word[7:0] :
                                    (effKind == ste_pkg::STE_IDLE)   ? `STE_K28_5 :
                                    (effKind == ste_pkg::STE_CAREXT) ? `STE_K23_7 :
                                    `STE_K30_7; // RL9 RL10 RL11
    wire [10:0]          loEnc    = encByte(loByte, !isData, rd); // RL7 RL15
    // Idle partner picked from the disparity after K28.5
    wire [7:0]           hiByte   = isData ? capt.word[15:8] :
                                    (effKind == ste_pkg::STE_IDLE) ?
                                    (loEnc[10] ? `STE_D16_2 : `STE_D5_6) : loByte; // RL16
    wire                 hiK      = !(isData || effKind == ste_pkg::STE_IDLE);
    wire [10:0]          hiEnc    = encByte(hiByte, hiK, loEnc[10]); // RL7 RL15
    wire                 startDone = (idleCount == 8'(START_IDLES - 1));

    // **********************************************
    // Word phase and capture
    // **********************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            phase <= 4'd0;
            capt  <= '{word: 16'h0000, kind: ste_pkg::STE_IDLE};
        end else begin
            phase <= next_phase;
            if (captureTick) begin
                capt <= '{word: txIn.word, kind: inKind}; // RL1
            end
        end
    end

    // Start-up idle counter and link state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state     <= ste_pkg::STE_START;
            idleCount <= 8'h00;
        end else if (encodeTick && state == ste_pkg::STE_START) begin
            idleCount <= idleCount + 8'h01;
            if (startDone) begin
                state <= ste_pkg::STE_RUN; // RL4
            end
        end
    end

    // Encode stage and disparity
    always_ff @(posedge clk) begin
        if (!rstn) begin
            codeWord <= 20'h00000;
            rd       <= 1'b0;
        end else if (encodeTick) begin
            codeWord <= {hiEnc[9:0], loEnc[9:0]}; // RL7 RL15
            rd       <= hiEnc[10]; // RL13
        end
    end

    // Serializer, two bits per cycle, low bit first
    always_ff @(posedge clk) begin
        if (!rstn) begin
            shifter    <= 18'h00000;
            serialPair <= 2'h0;
        end else if (encodeTick) begin
            serialPair <= codeWord[1:0]; // RL2 RL3 RL12
            shifter    <= codeWord[19:2];
        end else begin
            serialPair <= shifter[1:0]; // RL2 RL3
            shifter    <= {2'h0, shifter[17:2]};
        end
    end

    // Registered status outputs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wordTake <= 1'b0;
            linkUp   <= 1'b0;
        end else begin
            wordTake <= (next_phase == `STE_CAPTURE_PHASE);
            linkUp   <= (state == ste_pkg::STE_RUN);
        end
    end

    // **********************************************
    // Assertions
    // **********************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_capture;
        captureTick |=> capt.word == $past(txIn.word) && capt.kind == $past(inKind);
    endproperty
    a_capture: assert property (p_capture) else $error("word not captured"); // RL1

    property p_word_period;
        encodeTick |=> (!encodeTick)[*8] ##2 encodeTick;
    endproperty
    a_word_period: assert property (p_word_period) else $error("word period wrong"); // RL2

    property p_lsb_first;
        encodeTick |=> serialPair == $past(codeWord[1:0])
                       ##1 serialPair == $past(codeWord[3:2], 2);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("bit order wrong"); // RL3

    property p_start_comma;
        encodeTick && state == ste_pkg::STE_START |=>
            codeWord[9:0] == `STE_K28_5_NEG || codeWord[9:0] == `STE_K28_5_POS;
    endproperty
    a_start_comma: assert property (p_start_comma) else $error("no start comma"); // RL4

    property p_carext;
        encodeTick && effKind == ste_pkg::STE_CAREXT |=> codeWord[19:10] == codeWord[9:0]
            && (codeWord[9:0] == `STE_K23_7_NEG || codeWord[9:0] == `STE_K23_7_POS);
    endproperty
    a_carext: assert property (p_carext) else $error("carrier extend wrong"); // RL9

    property p_errprop;
        encodeTick && effKind == ste_pkg::STE_ERRPROP |=> codeWord[19:10] == codeWord[9:0]
            && (codeWord[9:0] == `STE_K30_7_NEG || codeWord[9:0] == `STE_K30_7_POS);
    endproperty
    a_errprop: assert property (p_errprop) else $error("error propagation wrong"); // RL10

    property p_idle_neg;
        encodeTick && effKind == ste_pkg::STE_IDLE && !rd |=> codeWord[9:0] == `STE_K28_5_NEG;
    endproperty
    a_idle_neg: assert property (p_idle_neg) else $error("idle comma pattern wrong"); // RL11

    property p_latency;
        captureTick |-> ##19 serialPair == $past(loEnc[1:0], 11);
    endproperty
    a_latency: assert property (p_latency) else $error("transmit latency wrong"); // RL12

    property p_balance;
        encodeTick |=> $countones(codeWord[9:0]) inside {4, 5, 6}
                       && $countones(codeWord[19:10]) inside {4, 5, 6};
    endproperty
    a_balance: assert property (p_balance) else $error("code word unbalanced"); // RL13

    property p_idle_rd;
        encodeTick && effKind == ste_pkg::STE_IDLE |=> !rd;
    endproperty
    a_idle_rd: assert property (p_idle_rd) else $error("idle left disparity positive"); // RL16

    c_data: cover property (encodeTick && effKind == ste_pkg::STE_DATA);
    c_carext: cover property (encodeTick && effKind == ste_pkg::STE_CAREXT);
    c_errprop: cover property (encodeTick && effKind == ste_pkg::STE_ERRPROP);
    c_link_up: cover property ($rose(linkUp));

endmodule

//--- verif/ste_protocol_partner.sv
`timescale 1ns/1ps

// ****************************************
// Protocol device on the transmit word bus
// ****************************************
module ste_protocol_partner (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rstn,
    // Transmit word bus
    input  wire logic           wordTake,
    output ste_pkg::ste_tx_in_s txIn
);
    // Words still to be presented, oldest first
    ste_pkg::ste_tx_in_s pending[$];

    // Queue one word with its framing controls
    function automatic void push(input logic fv, input logic er, input logic [15:0] w);
        pending.push_back('{word: w, frameValid: fv, txErrorCode: er});
    endfunction

    // Framing controls change only just after a capture edge
    always @(posedge clk) begin
        if (!rstn) begin
            txIn <= '0;
        end else if (wordTake) begin
            if (pending.size() != 0) begin
                txIn <= pending.pop_front();
            end else begin
                txIn <= '0;
            end
        end
    end
endmodule

//--- verif/ste_serdes_transmit_encoder_tb_top.sv
`timescale 1ns/1ps

module ste_serdes_transmit_encoder_tb_top;
    // ****************************************
    // Signals and reference tables
    // ****************************************
    localparam logic [5:0] TBL6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19,
        6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13,
        6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E,
        6'h2B};
    localparam logic [3:0] TBL4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    localparam logic [15:0] EDGE_WORDS [6] = '{16'h0000, 16'hFFFF, 16'hF1EB, 16'hBCBC,
        16'h07E7, 16'hEBF1};
    logic                clk;
    logic                rstn;
    ste_pkg::ste_tx_in_s txIn;
    logic                wordTake;
    logic [1:0]          serialPair;
    logic                linkUp;
    logic                rd;
    logic [19:0]         got;
    logic [19:0]         expCode[$];
    int                  expStart[$];
    int                  cyc;
    int                  lastTake;
    int                  num_errors;
    int                  total_checks;

    // Clock at 100 MHz
    initial clk = 1'b0;
    always #5 clk = ~clk;

    ste_serdes_transmit_encoder #(.START_IDLES(3)) ste_serdes_transmit_encoder_inst (
        .clk        (clk),
        .rstn       (rstn),
        .txIn       (txIn),
        .wordTake   (wordTake),
        .serialPair (serialPair),
        .linkUp     (linkUp)
    );

    ste_protocol_partner ste_protocol_partner_inst (
        .clk      (clk),
        .rstn     (rstn),
        .wordTake (wordTake),
        .txIn     (txIn)
    );

    // ****************************************
    // Reference encoder and checking
    // ****************************************
    // One character, ten bits with the first sent bit at bit 0; rd tracks disparity
    function automatic logic [9:0] enc8(input logic [7:0] b, input logic isK);
        logic [5:0] s;
        logic [3:0] f;
        int         x;
        int         y;
        x = b[4:0];
        y = b[7:5];
        s = (isK && x == 28) ? 6'h0F : TBL6[x];
        if ($countones(s) != 3 || x == 7) begin
            s = rd ? ~s : s;
            rd = ($countones(s) != 3) ? ~rd : rd;
        end
        f = TBL4[y];
        if (y == 7 && (isK || (!rd && (x == 17 || x == 18 || x == 20))
                || (rd && (x == 11 || x == 13 || x == 14)))) begin
            f = 4'h7;
        end
        // K28 entered at positive disparity inverts its balanced tail
        if (isK && x == 28 && !rd && $countones(f) == 2 && y != 3) begin
            f = ~f;
        end
        if ($countones(f) != 2 || y == 3) begin
            f = rd ? ~f : f;
            rd = ($countones(f) != 2) ? ~rd : rd;
        end
        return {<<{s, f}};
    endfunction

    // Twenty-bit code word for one presented word, low byte first
    function automatic logic [19:0] enc20(input ste_pkg::ste_tx_in_s t);
        logic [9:0] lo;
        logic [9:0] hi;
        case ({t.frameValid, t.txErrorCode})
            2'b10: begin
                lo = enc8(t.word[7:0], 1'b0);
                hi = enc8(t.word[15:8], 1'b0);
            end
            2'b01: begin
                lo = enc8(8'hF7, 1'b1);
                hi = enc8(8'hF7, 1'b1);
            end
            2'b11: begin
                lo = enc8(8'hFE, 1'b1);
                hi = enc8(8'hFE, 1'b1);
            end
            default: begin
                lo = enc8(8'hBC, 1'b1);
                hi = enc8(rd ? 8'h50 : 8'hC5, 1'b0);
            end
        endcase
        return {hi, lo};
    endfunction

    // Compare and count
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic final_report();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Model each capture and compare each serialized word, sampled mid-cycle
    always @(negedge clk) begin
        cyc++;
        if (rstn && wordTake) begin
            if (lastTake != 0) check(20'(cyc - lastTake), 20'hA);
            if (txIn.frameValid) check({19'h0, linkUp}, 20'h1);
            lastTake = cyc;
            expCode.push_back(enc20(txIn));
            expStart.push_back(cyc + 19);
        end
        if (expStart.size() != 0 && cyc >= expStart[0]) begin
            got[2 * (cyc - expStart[0]) +: 2] = serialPair;
            if (cyc - expStart[0] == 9) begin
                check(got, expCode.pop_front());
                void'(expStart.pop_front());
            end
        end
    end

    // ****************************************
    // Test sequence and watchdog
    // ****************************************
    initial begin
        rstn = 1'b0;
        rd = 1'b0;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(32'h8DD4));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        check({19'h0, linkUp}, 20'h0);
        // Start-up idles, then boundary and random data words
        for (int i = 0; i < 4; i++) begin
            ste_protocol_partner_inst.push(1'b0, 1'b0, 16'h0000);
        end
        for (int i = 0; i < 6; i++) begin
            ste_protocol_partner_inst.push(1'b1, 1'b0, EDGE_WORDS[i]);
        end
        for (int i = 0; i < 12; i++) begin
            ste_protocol_partner_inst.push(1'b1, 1'b0, 16'($urandom()));
        end
        // Every control combination, then a random mix
        for (int i = 0; i < 8; i++) begin
            ste_protocol_partner_inst.push(i[1], i[0], 16'($urandom()));
        end
        for (int i = 0; i < 24; i++) begin
            ste_protocol_partner_inst.push(1'($urandom()), 1'($urandom()), 16'($urandom()));
        end
        for (int i = 0; i < 2000 && ste_protocol_partner_inst.pending.size() != 0; i++) begin
            @(negedge clk);
        end
        // Last capture plus full latency
        repeat (40) @(negedge clk);
        final_report();
    end

    // Cuts a hang short
    initial begin
        #100000;
        num_errors++;
        final_report();
    end
endmodule
